// *** pmtf_consts.vh ***
// Purpose: Constants for the pin monitor and transmit framing register bank
// Assumes: Byte-wide registers on a plain host register port
// Notes:   Reserved bits are masked on write so they always read zero
// Function
// - Pin snapshot read returns eight pin input levels in bits 7..0.
// - Pad speed bit 7 set selects fast pad switching, clear normal.
// - Select codes 0h and 1h leave the debug output pin undriven.
// - Select 2h drives debug pin low, 3h drives it high.
// - Select 4h, 5h, 6h route tx envelope, tx active, secure module signal.
// - Select 7h, 8h, 9h route rx envelope, rx active, rx bit signal.
// - Rx envelope on the debug pin is valid only in type A 106 kBd.
// - Framing bit 7 set sends high bit first, clear low bit first.
// - Framing bit 5 set gives odd parity, clear gives even parity.
// - Framing bit 3 gives the stop bit level.
// - Framing bit 1 gives the start bit level.
// - Framing bit 0 set sends a start bit, clear sends none.
`ifndef PMTF_CONSTS_VH
`define PMTF_CONSTS_VH

`define PMTF_ADDR_PIN_IN   8'h46
`define PMTF_ADDR_SIG_OUT  8'h47
`define PMTF_ADDR_FRAMING  8'h48

`define PMTF_SIG_WMASK     8'h8f
`define PMTF_FRM_WMASK     8'hab
`define PMTF_SIG_RESET     8'h00
`define PMTF_FRM_RESET     8'h00

`define PMTF_SIG_SPEED_BIT 7
`define PMTF_FRM_MSB_BIT   7
`define PMTF_FRM_ODD_BIT   5
`define PMTF_FRM_STOP_BIT  3
`define PMTF_FRM_SLVL_BIT  1
`define PMTF_FRM_SEN_BIT   0

`define PMTF_SEL_Z0        4'h0
`define PMTF_SEL_Z1        4'h1
`define PMTF_SEL_LOW       4'h2
`define PMTF_SEL_HIGH      4'h3
`define PMTF_SEL_TX_ENV    4'h4
`define PMTF_SEL_TX_ACT    4'h5
`define PMTF_SEL_SECURE    4'h6
`define PMTF_SEL_RX_ENV    4'h7
`define PMTF_SEL_RX_ACT    4'h8
`define PMTF_SEL_RX_BIT    4'h9

`endif

// *** pmtf_regs.v ***
// Purpose: Pin snapshot, debug output select and transmit framing registers
// Assumes: Pin levels and internal signals are synchronous to sys_clk
// Notes:   Read data stand one cycle after the read strobe; unmapped reads give zero
`include "pmtf_consts.vh"
`timescale 1ns/10ps
`default_nettype none

module pmtf_regs
(
  input  wire       sys_clk,
  input  wire       rst,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  input  wire       signal_input_pin,
  input  wire       clock_output_pin,
  input  wire       host_iface_select_pin1,
  input  wire       host_iface_select_pin0,
  input  wire [3:0] scan_pin_level,
  input  wire       tx_envelope,
  input  wire       tx_active,
  input  wire       secure_module_signal,
  input  wire       rx_envelope,
  input  wire       rx_envelope_valid,
  input  wire       rx_active,
  input  wire       rx_bit,
  output reg        debug_signal_output_pin,
  output reg        debug_signal_output_oe,
  output reg        fast_pad_enable,
  output reg        tx_high_bit_first,
  output reg        tx_odd_parity_select,
  output reg        tx_stop_level,
  output reg        tx_start_level,
  output reg        tx_start_bit_enable
);

  reg  [7:0] sig_out_q;
  reg  [7:0] framing_q;
  reg  [7:0] rdata_d;
  reg        dbg_d;
  reg        dbg_oe_d;
  wire [3:0] debug_output_select;
  wire [7:0] pin_snapshot;

  assign debug_output_select = sig_out_q[3:0];

  // Live input levels, bit 7 down to bit 0
  assign pin_snapshot = {signal_input_pin, clock_output_pin, host_iface_select_pin1,
                         host_iface_select_pin0, scan_pin_level};

  // Register writes; reserved bits are masked off and stay zero
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      sig_out_q <= `PMTF_SIG_RESET;
      framing_q <= `PMTF_FRM_RESET;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `PMTF_ADDR_SIG_OUT)
        sig_out_q <= reg_wdata & `PMTF_SIG_WMASK;
      if (reg_addr == `PMTF_ADDR_FRAMING)
        framing_q <= reg_wdata & `PMTF_FRM_WMASK;
    end
  end

  // Read mux
  always @*
  begin
    rdata_d = 8'h00;
    case (reg_addr)
      `PMTF_ADDR_PIN_IN:  rdata_d = pin_snapshot;
      `PMTF_ADDR_SIG_OUT: rdata_d = sig_out_q;
      `PMTF_ADDR_FRAMING: rdata_d = framing_q;
      default:            rdata_d = 8'h00;
    endcase
  end

  // Debug output pin source
  always @*
  begin
    dbg_d    = 1'b0;
    dbg_oe_d = 1'b1;
    case (debug_output_select)
      `PMTF_SEL_Z0:     dbg_oe_d = 1'b0;
      `PMTF_SEL_Z1:     dbg_oe_d = 1'b0;
      `PMTF_SEL_LOW:    dbg_d    = 1'b0;
      `PMTF_SEL_HIGH:   dbg_d    = 1'b1;
      `PMTF_SEL_TX_ENV: dbg_d    = tx_envelope;
      `PMTF_SEL_TX_ACT: dbg_d    = tx_active;
      `PMTF_SEL_SECURE: dbg_d    = secure_module_signal;
      // Outside type A 106 kBd the envelope is not meaningful, so hold low
      `PMTF_SEL_RX_ENV: dbg_d    = rx_envelope & rx_envelope_valid;
      `PMTF_SEL_RX_ACT: dbg_d    = rx_active;
      `PMTF_SEL_RX_BIT: dbg_d    = rx_bit;
      default:          dbg_oe_d = 1'b0;
    endcase
  end

  // All outputs registered
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      reg_rdata               <= 8'h00;
      debug_signal_output_pin <= 1'b0;
      debug_signal_output_oe  <= 1'b0;
      fast_pad_enable         <= 1'b0;
      tx_high_bit_first       <= 1'b0;
      tx_odd_parity_select    <= 1'b0;
      tx_stop_level           <= 1'b0;
      tx_start_level          <= 1'b0;
      tx_start_bit_enable     <= 1'b0;
    end
    else
    begin
      reg_rdata               <= reg_rd ? rdata_d : 8'h00;
      debug_signal_output_pin <= dbg_d;
      debug_signal_output_oe  <= dbg_oe_d;
      fast_pad_enable         <= sig_out_q[`PMTF_SIG_SPEED_BIT];
      tx_high_bit_first       <= framing_q[`PMTF_FRM_MSB_BIT];
      tx_odd_parity_select    <= framing_q[`PMTF_FRM_ODD_BIT];
      tx_stop_level           <= framing_q[`PMTF_FRM_STOP_BIT];
      tx_start_level          <= framing_q[`PMTF_FRM_SLVL_BIT];
      tx_start_bit_enable     <= framing_q[`PMTF_FRM_SEN_BIT];
    end
  end

endmodule // pmtf_regs

`default_nettype wire

// *** pmtf_regs_checker.sv ***
// Purpose: Port checks on pmtf_regs
// Assumes: Bound from the bench
// Notes:   Outputs lag a write by two cycles
`timescale 1ns/10ps
`default_nettype none
module pmtf_regs_checker
(
  input wire       sys_clk, rst, reg_wr, reg_rd,
  input wire [7:0] reg_addr, reg_wdata, reg_rdata,
  input wire       debug_signal_output_pin, debug_signal_output_oe,
  input wire       fast_pad_enable, tx_high_bit_first, tx_odd_parity_select, tx_start_bit_enable
);
  wire       wf = reg_wr && reg_addr == 8'h48;
  wire       ws = reg_wr && reg_addr == 8'h47;
  wire [3:0] c = reg_wdata[3:0];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_cfg(logic w, int b, logic o);
    w ##1 !w |-> ##1 o == $past(reg_wdata[b], 2);
  endproperty
  property p_dbg(logic k, logic v);
    ws && k ##1 !ws |-> ##1 v;
  endproperty
  a_pad_speed: assert property (p_cfg(ws, 7, fast_pad_enable)) else $error("pad");
  a_msb_order: assert property (p_cfg(wf, 7, tx_high_bit_first)) else $error("order");
  a_parity_sense: assert property (p_cfg(wf, 5, tx_odd_parity_select)) else $error("parity");
  a_start_enable: assert property (p_cfg(wf, 0, tx_start_bit_enable)) else $error("start");
  a_rsvd_zero: assert property (reg_rd && reg_addr == 8'h48 |=> !(reg_rdata & 8'h54)) else $error("rsvd");
  a_pin_float: assert property (p_dbg(c < 2 || c > 9, !debug_signal_output_oe)) else $error("float");
  a_pin_high: assert property (p_dbg(c == 3, debug_signal_output_oe && debug_signal_output_pin)) else $error("high");
  a_pin_low: assert property (p_dbg(c == 2, debug_signal_output_oe && !debug_signal_output_pin)) else $error("low");
  cover property (wf);
  cover property (ws && c == 7);
  cover property (reg_rd && reg_addr == 8'h46);
endmodule // pmtf_regs_checker
`default_nettype wire

// *** pmtf_regs_tb.sv ***
// Purpose: Self-checking bench for pmtf_regs
// Assumes: 40 MHz clock
// Notes:   Rows first, then hand tests
`timescale 1ns/10ps
`default_nettype none
module pmtf_regs_tb;
  reg        sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, rx_envelope_valid = 1;
  reg  [7:0] reg_addr = 0, reg_wdata = 0;
  reg  [3:0] scan_pin_level = 0;
  reg        signal_input_pin = 0, clock_output_pin = 0, host_iface_select_pin1 = 0, host_iface_select_pin0 = 0;
  reg        tx_envelope = 0, tx_active = 0, secure_module_signal = 0, rx_envelope = 0, rx_active = 0, rx_bit = 0;
  wire [7:0] reg_rdata;
  wire       debug_signal_output_pin, debug_signal_output_oe, fast_pad_enable, tx_high_bit_first;
  wire       tx_odd_parity_select, tx_stop_level, tx_start_level, tx_start_bit_enable;
  wire [4:0] frm = {tx_high_bit_first, tx_odd_parity_select, tx_stop_level, tx_start_level, tx_start_bit_enable};
  integer    n_mismatch = 0, compares = 0, cyc = 0, i;
  reg [15:0] rows [0:2];
  always #12.5 sys_clk = ~sys_clk;
  pmtf_regs i_pmtf_regs (.*);
  task chk(input [7:0] got, exp);
  begin
    compares = compares + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask
  task wr(input [7:0] a, d);
  begin
    @(posedge sys_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge sys_clk);
    reg_wr <= 0;
    @(posedge sys_clk);
    @(negedge sys_clk);
  end
  endtask
  task rd(input [7:0] a, e);
  begin
    @(posedge sys_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge sys_clk);
    reg_rd <= 0;
    @(negedge sys_clk);
    chk(reg_rdata, e);
  end
  endtask
  task close_out;
  begin
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  always @(posedge sys_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 900)
    begin
      n_mismatch = n_mismatch + 1;
      close_out;
    end
  end
  initial
  begin
    rows[0] = 16'hffab;
    rows[1] = 16'h5501;
    rows[2] = 16'haaaa;
    repeat (5) @(posedge sys_clk);
    rst <= 0;
    for (i = 0; i < 3; i = i + 1)
    begin
      wr(8'h48, rows[i][15:8]);
      chk(frm, {rows[i][7], rows[i][5], rows[i][3], rows[i][1:0]});
      rd(8'h48, rows[i][7:0]);
    end
    $display("framing done");
    wr(8'h47, 8'hff);
    rd(8'h47, 8'h8f);
    chk(fast_pad_enable, 1);
    for (i = 0; i < 16; i = i + 1)
    begin
      @(posedge sys_clk);
      {tx_envelope, tx_active, secure_module_signal, rx_envelope, rx_active, rx_bit} <= 6'h20 >> (i - 4);
      wr(8'h47, i[7:0]);
      chk({debug_signal_output_oe, debug_signal_output_pin}, {i > 1 && i < 10, i > 2 && i < 10});
    end
    @(posedge sys_clk);
    {rx_envelope, rx_envelope_valid} <= 2'b10;
    {signal_input_pin, clock_output_pin, host_iface_select_pin1, host_iface_select_pin0, scan_pin_level} <= 8'ha5;
    wr(8'h47, 8'h07);
    chk({debug_signal_output_oe, debug_signal_output_pin}, 2'b10);
    wr(8'h46, 8'h00);
    rd(8'h46, 8'ha5);
    rd(8'h50, 8'h00);
    $display("select and snapshot done");
    @(posedge sys_clk);
    rst <= 1;
    repeat (2) @(posedge sys_clk);
    rst <= 0;
    @(negedge sys_clk);
    chk({debug_signal_output_oe, debug_signal_output_pin, fast_pad_enable, frm}, 8'h00);
    chk(reg_rdata, 8'h00);
    rd(8'h48, 8'h00);
    rd(8'h47, 8'h00);
    $display("reset done");
    close_out;
  end
endmodule // pmtf_regs_tb
bind pmtf_regs pmtf_regs_checker i_pmtf_regs_checker (.*);
`default_nettype wire
